// ===== include/lvd_regs.svh
`ifndef LVD_REGS_SVH
`define LVD_REGS_SVH

// register byte addresses on the internal bus
`define LVD_CTRL_ADDR 16'hffbe
`define LVD_LEVEL_ADDR 16'hffbf
`define LVD_P12DIR_ADDR 16'hff2c

// reset values
`define LVD_CTRL_RESET 8'h00
`define LVD_LEVEL_RESET 8'h00
`define LVD_P12DIR_RESET 8'hff
`define LVD_MASK_RESET 1'b1

// control register fields
`define LVD_CTRL_ON_BIT 7
`define LVD_CTRL_SRC_BIT 2
`define LVD_CTRL_MODE_BIT 1
`define LVD_CTRL_FLAG_BIT 0
`define LVD_CTRL_WR_MASK 8'h86

// level select fields
`define LVD_LEVEL_WR_MASK 8'h0f
`define LVD_EXT_LEVEL_CODE 4'h0

// port 12 direction fields
`define LVD_P12DIR_WR_MASK 8'h1f
`define LVD_P12DIR_FIXED 8'he0
`define LVD_P12_SENSE_BIT 0

// comparator settling time software must wait, in ns
`define LVD_SETTLE_NS 10000

`endif

// ===== include/lvd_pkg.sv
package lvd_pkg;

  typedef logic [7:0] lvd_byte_t;
  typedef logic [3:0] lvd_code_t;

  typedef enum logic {
    LVD_SRC_SUPPLY,
    LVD_SRC_EXT
  } lvd_src_e;

  typedef enum logic {
    LVD_MODE_IRQ,
    LVD_MODE_RESET
  } lvd_mode_e;

endpackage

// ===== src/lvd_sync.sv
`timescale 1ns/1ns
module lvd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

// ===== src/lvd_control.sv
`timescale 1ns/1ns
`include "lvd_regs.svh"

// Operation
// - any reset clears level select register
// - drive 4-bit level code to comparator
// - external source uses fixed threshold, ignores level
// - every reset sets port 12 direction to ones
// - direction 0 drives output, 1 input
// - supply reset mode: reset while below threshold
// - pin reset mode: reset while pin below threshold
// - interrupt mode: interrupt on every result change
// - below flag readable at control bit 0
// - enabling detection may raise interrupt at once
// - no reset if level fine when mode set
// - any reset sets interrupt mask flag
// - detector reset sets reset cause bit 0
// - control resets zero; bits 7,2,1,0 defined
// - detector reset keeps enable, source, mode bits
// - flag routes to interrupt only when on, irq mode
module lvd_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // internal register bus, byte wide, bit writes through mask
  input wire logic [15:0] busAddr,
  input wire logic busWrEn,
  input wire logic [7:0] busWrMask,
  input wire logic [7:0] busWrData,
  input wire logic busRdEn,
  output logic [7:0] busRdData,
  // interrupt controller side
  input wire logic maskWrEn,
  input wire logic maskWrData,
  output logic lowvoltIrqMask,
  output logic lowvoltIrq,
  // reset controller side
  input wire logic causeClear,
  output logic lowvoltReset,
  output logic lowvoltResetCause,
  // analog comparator
  input wire logic compBelowAsync,
  output logic compOn,
  output logic compExtSource,
  output logic [3:0] compLevelCode,
  // port 12 pins
  output logic [4:0] port12OutEn,
  output logic senseInputSel
);

  ////////////////////////////////////////////////////////////////////////
  // state

  logic detOn_reg;
  logic detOn_next;
  lvd_pkg::lvd_src_e srcSel_reg;
  lvd_pkg::lvd_src_e srcSel_next;
  lvd_pkg::lvd_mode_e modeSel_reg;
  lvd_pkg::lvd_mode_e modeSel_next;
  lvd_pkg::lvd_code_t level_reg;
  lvd_pkg::lvd_code_t level_next;
  logic [4:0] p12Dir_reg;
  logic [4:0] p12Dir_next;
  logic irqMask_reg;
  logic irqMask_next;
  logic cause_reg;
  logic cause_next;
  logic detReset_reg;
  logic detReset_next;
  logic irqSrcPrev_reg;
  logic irqSrcPrev_next;
  logic irq_reg;
  logic irq_next;
  lvd_pkg::lvd_byte_t rdData_reg;
  lvd_pkg::lvd_byte_t rdData_next;

  logic below;
  logic belowFlag;
  logic irqSource;
  lvd_pkg::lvd_byte_t ctrlWord;
  lvd_pkg::lvd_byte_t levelWord;
  lvd_pkg::lvd_byte_t p12Word;
  lvd_pkg::lvd_byte_t wrCtrl;
  lvd_pkg::lvd_byte_t wrLevel;
  lvd_pkg::lvd_byte_t wrP12;
  logic selCtrl;
  logic selLevel;
  logic selP12;

  ////////////////////////////////////////////////////////////////////////
  // comparator input

  lvd_sync #(
    .WIDTH(1)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn(compBelowAsync),
    .syncOut(below)
  );

  // flag reads zero while the detector is off
  assign belowFlag = detOn_reg & below;
  assign irqSource = belowFlag & (modeSel_reg == lvd_pkg::LVD_MODE_IRQ);

  ////////////////////////////////////////////////////////////////////////
  // register views

  always_comb begin
    ctrlWord = 8'h00;
    ctrlWord[`LVD_CTRL_ON_BIT] = detOn_reg;
    ctrlWord[`LVD_CTRL_SRC_BIT] = (srcSel_reg == lvd_pkg::LVD_SRC_EXT);
    ctrlWord[`LVD_CTRL_MODE_BIT] = (modeSel_reg == lvd_pkg::LVD_MODE_RESET);
    ctrlWord[`LVD_CTRL_FLAG_BIT] = belowFlag;
    levelWord = {4'h0, level_reg};
    p12Word = `LVD_P12DIR_FIXED | {3'h0, p12Dir_reg};
  end

  // address decode
  always_comb begin
    selCtrl = 1'b0;
    selLevel = 1'b0;
    selP12 = 1'b0;
    if (busAddr == `LVD_CTRL_ADDR) begin
      selCtrl = 1'b1;
    end else if (busAddr == `LVD_LEVEL_ADDR) begin
      selLevel = 1'b1;
    end else if (busAddr == `LVD_P12DIR_ADDR) begin
      selP12 = 1'b1;
    end
  end

  // bit writes only touch the masked lanes; read-only and fixed bits ignore writes
  always_comb begin
    wrCtrl = (ctrlWord & ~(busWrMask & `LVD_CTRL_WR_MASK))
      | (busWrData & busWrMask & `LVD_CTRL_WR_MASK);
    wrLevel = (levelWord & ~(busWrMask & `LVD_LEVEL_WR_MASK))
      | (busWrData & busWrMask & `LVD_LEVEL_WR_MASK);
    wrP12 = (p12Word & ~(busWrMask & `LVD_P12DIR_WR_MASK))
      | (busWrData & busWrMask & `LVD_P12DIR_WR_MASK);
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits: only the external reset clears them

  always_comb begin
    detOn_next = detOn_reg;
    srcSel_next = srcSel_reg;
    modeSel_next = modeSel_reg;
    if (busWrEn && selCtrl) begin
      detOn_next = wrCtrl[`LVD_CTRL_ON_BIT];
      srcSel_next = lvd_pkg::lvd_src_e'(wrCtrl[`LVD_CTRL_SRC_BIT]);
      modeSel_next = lvd_pkg::lvd_mode_e'(wrCtrl[`LVD_CTRL_MODE_BIT]);
    end
  end

  // own reset skips these, else the detector would switch itself off
  always_ff @(posedge clk) begin
    if (rst) begin
      detOn_reg <= 1'b0;
      srcSel_reg <= lvd_pkg::LVD_SRC_SUPPLY;
      modeSel_reg <= lvd_pkg::LVD_MODE_IRQ;
    end else begin
      detOn_reg <= detOn_next;
      srcSel_reg <= srcSel_next;
      modeSel_reg <= modeSel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level, direction and mask: any reset restores them

  always_comb begin
    level_next = level_reg;
    p12Dir_next = p12Dir_reg;
    irqMask_next = irqMask_reg;
    if (busWrEn && selLevel) begin
      level_next = wrLevel[3:0];
    end
    if (busWrEn && selP12) begin
      p12Dir_next = wrP12[4:0];
    end
    if (maskWrEn) begin
      irqMask_next = maskWrData;
    end
    // own reset beats a write in the same cycle
    if (detReset_reg) begin
      level_next = 4'(`LVD_LEVEL_RESET);
      p12Dir_next = 5'(`LVD_P12DIR_RESET);
      irqMask_next = `LVD_MASK_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 4'(`LVD_LEVEL_RESET);
      p12Dir_reg <= 5'(`LVD_P12DIR_RESET);
      irqMask_reg <= `LVD_MASK_RESET;
    end else begin
      level_reg <= level_next;
      p12Dir_reg <= p12Dir_next;
      irqMask_reg <= irqMask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset request and interrupt

  always_comb begin
    // level sensitive: selecting reset mode while fine does nothing
    detReset_next = detOn_reg & below
      & (modeSel_reg == lvd_pkg::LVD_MODE_RESET);
    // any change of the gated flag while on in irq mode, including the one from enabling
    irqSrcPrev_next = irqSource;
    irq_next = (irqSource != irqSrcPrev_reg) & detOn_reg
      & (modeSel_reg == lvd_pkg::LVD_MODE_IRQ);
  end

  // registered so no decode glitch reaches the reset tree
  always_ff @(posedge clk) begin
    if (rst) begin
      detReset_reg <= 1'b0;
      irqSrcPrev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      detReset_reg <= detReset_next;
      irqSrcPrev_reg <= irqSrcPrev_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset cause

  always_comb begin
    cause_next = cause_reg;
    if (causeClear) begin
      cause_next = 1'b0;
    end
    // set wins over clear, so a cause is never lost
    if (detReset_reg) begin
      cause_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cause_reg <= 1'b0;
    end else begin
      cause_reg <= cause_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  always_comb begin
    rdData_next = rdData_reg;
    if (busRdEn) begin
      if (selCtrl) begin
        rdData_next = ctrlWord;
      end else if (selLevel) begin
        rdData_next = levelWord;
      end else if (selP12) begin
        rdData_next = p12Word;
      end else begin
        rdData_next = 8'h00;
      end
    end
  end

  // held between reads, so a slow reader still sees one byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign busRdData = rdData_reg;
  assign lowvoltIrqMask = irqMask_reg;
  assign lowvoltIrq = irq_reg;
  assign lowvoltReset = detReset_reg;
  assign lowvoltResetCause = cause_reg;
  assign compOn = detOn_reg;
  assign compExtSource = (srcSel_reg == lvd_pkg::LVD_SRC_EXT);
  // fixed reference on the pin path, so the code is parked
  assign compLevelCode = compExtSource ? `LVD_EXT_LEVEL_CODE : level_reg;
  assign port12OutEn = ~p12Dir_reg;
  // pin only usable as sense input when set to input mode
  assign senseInputSel = p12Dir_reg[`LVD_P12_SENSE_BIT];

endmodule

// ===== testbench/lvd_control_assertions.sv
`timescale 1ns/1ns
module lvd_control_chk (
  // clock
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic [15:0] busAddr,
  input wire logic busWrEn,
  input wire logic [7:0] busWrMask,
  input wire logic [7:0] busWrData,
  input wire logic causeClear,
  // outputs
  input wire logic lowvoltIrqMask,
  input wire logic lowvoltReset,
  input wire logic lowvoltResetCause,
  input wire logic compBelowAsync,
  input wire logic compOn,
  input wire logic compExtSource,
  input wire logic [3:0] compLevelCode,
  input wire logic [4:0] port12OutEn,
  input wire logic senseInputSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // own reset beats level and direction writes
  logic wrLvl;
  logic wrDir;
  assign wrLvl = busWrEn && busWrMask == 8'hff && busAddr == 16'hffbf && !lowvoltReset;
  assign wrDir = busWrEn && busWrMask == 8'hff && busAddr == 16'hff2c && !lowvoltReset;
  ////////////////////////////////
  a_reset_defaults:
    assert property ($fell(rst) |-> !compOn && compLevelCode == 4'h0 && port12OutEn == 5'h00
      && lowvoltIrqMask) else $error("state after reset wrong");
  a_ext_fixed:
    assert property (compExtSource |-> compLevelCode == 4'h0) else $error("ext level not fixed");
  a_level_write:
    assert property (wrLvl && !compExtSource |=> compLevelCode == 4'($past(busWrData)))
    else $error("level code not written");
  a_dir_write:
    assert property (wrDir |=> port12OutEn == ~5'($past(busWrData)))
    else $error("direction not written");
  a_dir_pin:
    assert property (senseInputSel != port12OutEn[0]) else $error("sense select wrong");
  a_own_clear:
    assert property (lowvoltReset |=> compLevelCode == 4'h0 && port12OutEn == 5'h00
      && lowvoltIrqMask && lowvoltResetCause) else $error("own reset effects missing");
  a_keep_ctrl:
    assert property (lowvoltReset && !busWrEn |=> $stable(compOn) && $stable(compExtSource))
    else $error("control lost in own reset");
  a_reset_cause:
    assert property (lowvoltReset |-> $past(compBelowAsync, 3)) else $error("reset without low");
  a_cause_clear:
    assert property (causeClear && !lowvoltReset |=> !lowvoltResetCause)
    else $error("cause not cleared");
endmodule

bind lvd_control lvd_control_chk chk (.clk, .rst, .busAddr, .busWrEn, .busWrMask, .busWrData,
  .causeClear, .lowvoltIrqMask, .lowvoltReset, .lowvoltResetCause, .compBelowAsync, .compOn,
  .compExtSource, .compLevelCode, .port12OutEn, .senseInputSel);

// ===== testbench/lvd_comp_model.sv
`timescale 1ns/1ns
// step 0 is the highest supply; a larger step is a lower one
module lvd_comp_model (
  // block side
  input wire logic compOn,
  input wire logic compExtSource,
  input wire logic [3:0] compLevelCode,
  // analog stand-ins
  input wire logic [4:0] supplyStep,
  input wire logic pinLow,
  // result
  output logic compBelowAsync
);
  // pin source ignores the code, its threshold is fixed
  assign compBelowAsync = compOn &&
    (compExtSource ? pinLow : supplyStep > {1'b0, compLevelCode});
endmodule

// ===== testbench/lvd_control_test.sv
`timescale 1ns/1ns
module lvd_control_test;
  logic clk, rst, busWrEn, busRdEn, maskWrEn, maskWrData, causeClear, pinLow;
  logic [15:0] busAddr;
  logic [7:0] busWrMask, busWrData, busRdData;
  logic [4:0] port12OutEn, supplyStep;
  logic [3:0] compLevelCode;
  logic lowvoltIrqMask, lowvoltIrq, lowvoltReset, lowvoltResetCause;
  logic compBelowAsync, compOn, compExtSource, senseInputSel;
  int mismatches, checksDone;
  lvd_control dut (.clk, .rst, .busAddr, .busWrEn, .busWrMask, .busWrData, .busRdEn,
    .busRdData, .maskWrEn, .maskWrData, .lowvoltIrqMask, .lowvoltIrq, .causeClear,
    .lowvoltReset, .lowvoltResetCause, .compBelowAsync, .compOn, .compExtSource,
    .compLevelCode, .port12OutEn, .senseInputSel);
  lvd_comp_model partner (.compOn, .compExtSource, .compLevelCode, .supplyStep, .pinLow,
    .compBelowAsync);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] m, input logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrMask <= m;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge clk);
    busWrEn <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge clk);
    busRdEn <= 1'b0;
    #1 chk($sformatf("reg %h", a), busRdData, e);
  endtask
  // pulses counted over a fixed span so a double pulse shows
  task automatic irqs(input logic [7:0] e);
    int k;
    k = 0;
    repeat (6) begin
      @(posedge clk);
      #1 k = k + int'(lowvoltIrq === 1'b1);
    end
    chk("irq count", 8'(k), e);
  endtask
  task automatic waitRst(input logic e);
    int n;
    n = 0;
    while (lowvoltReset !== e && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk("reset out", 8'(lowvoltReset), 8'(e));
    if (lowvoltReset !== e) test_done();
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    rst = 1'b1;
    {busWrEn, busRdEn, maskWrEn, maskWrData, causeClear, pinLow} = 6'h00;
    busAddr = 16'h0000;
    busWrMask = 8'h00;
    busWrData = 8'h00;
    supplyStep = 5'h05;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(16'hffbe, 8'h00);
    rd(16'hffbf, 8'h00);
    rd(16'hff2c, 8'hff);
    rd(16'hffc0, 8'h00);
    chk("mask", 8'(lowvoltIrqMask), 8'h01);
    $display("test defaults done");
    for (int c = 0; c < 16; c++) begin
      wr(16'hffbf, 8'hff, 8'(c));
      chk("level code", 8'(compLevelCode), 8'(c));
    end
    wr(16'hff2c, 8'hff, 8'h00);
    rd(16'hff2c, 8'he0);
    chk("out enable", 8'(port12OutEn), 8'h1f);
    wr(16'hff2c, 8'h01, 8'h01);
    chk("sense input", 8'(senseInputSel), 8'h01);
    $display("test registers done");
    @(posedge clk) maskWrEn <= 1'b1;
    @(posedge clk) maskWrEn <= 1'b0;
    #1 chk("mask", 8'(lowvoltIrqMask), 8'h00);
    wr(16'hffbf, 8'hff, 8'h08);
    wr(16'hffbe, 8'hff, 8'h80);
    irqs(8'h00);
    @(posedge clk) supplyStep <= 5'h0c;
    irqs(8'h01);
    rd(16'hffbe, 8'h81);
    @(posedge clk) supplyStep <= 5'h05;
    irqs(8'h01);
    wr(16'hffbe, 8'hff, 8'h00);
    @(posedge clk) pinLow <= 1'b1;
    wr(16'hffbe, 8'hff, 8'h84);
    irqs(8'h01);
    chk("ext level", 8'(compLevelCode), 8'h00);
    @(posedge clk) pinLow <= 1'b0;
    irqs(8'h01);
    $display("test interrupt done");
    wr(16'hffbe, 8'hff, 8'h00);
    wr(16'hffbe, 8'hff, 8'h80);
    repeat (500) @(posedge clk);
    rd(16'hffbe, 8'h80);
    wr(16'hffbe, 8'hff, 8'h82);
    rd(16'hffbe, 8'h82);
    chk("no reset", 8'(lowvoltReset), 8'h00);
    @(posedge clk) supplyStep <= 5'h0c;
    waitRst(1'b1);
    rd(16'hffbf, 8'h00);
    rd(16'hff2c, 8'hff);
    rd(16'hffbe, 8'h83);
    chk("cause", 8'(lowvoltResetCause), 8'h01);
    chk("mask", 8'(lowvoltIrqMask), 8'h01);
    @(posedge clk) supplyStep <= 5'h00;
    waitRst(1'b0);
    @(posedge clk) causeClear <= 1'b1;
    @(posedge clk) causeClear <= 1'b0;
    #1 chk("cause", 8'(lowvoltResetCause), 8'h00);
    $display("test supply reset done");
    wr(16'hffbe, 8'hff, 8'h00);
    wr(16'hffbe, 8'hff, 8'h84);
    wr(16'hffbe, 8'hff, 8'h86);
    @(posedge clk) pinLow <= 1'b1;
    irqs(8'h00);
    waitRst(1'b1);
    wr(16'hffbe, 8'h02, 8'h00);
    waitRst(1'b0);
    wr(16'hffbe, 8'h80, 8'h00);
    rd(16'hffbe, 8'h04);
    $display("test pin reset done");
    @(posedge clk) maskWrEn <= 1'b1;
    @(posedge clk) maskWrEn <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(16'hffbe, 8'h00);
    chk("mask", 8'(lowvoltIrqMask), 8'h01);
    $display("test external reset done");
    test_done();
  end
endmodule
